// *** logic/boot_power_seq.v ***
// Contract
// - An external-switch dead-battery strap drives the sink gate pin.
// - Internal-switch dead-battery straps sink on the first HV path.
// - Power-up from either supply tries a load before any default.
// - Safe default keeps ports off, a legacy sink when on bus power.
// - Infinite wait default stays in boot until configuration arrives.
// - Profile 1: internal-switch source only, 5 V 3 A, no PD.
// - Profile 2: internal source only, 45 W 5/9/15/20 V, no alt modes.
// - Profile 3: internal sink only, 5-20 V at 0.9-3.0 A, no alt modes.
// - Profile 4: internal source only, 60 W 5/9/15/20 V, no alt modes.
// - Profile 5: external sink plus 5 V 3 A source, no alt modes.
// - One of Active, Idle, Sleep holds; Sleep only while unconnected.
// - Core clock 12 MHz, 5 MHz, 100 kHz; fast oscillator off in Sleep. Active runs 12.5 MHz here (250 MHz over 20).
// - Detection always; PD and SPI only in Active; I2C also in Idle.
// - Attach, detach or addressed I2C wakes Idle or Sleep to Active.
// - A PD message wakes only from Idle and that message is dropped.
// - When the regulator runs from bus power the port is sink only.
`timescale 1ns/1ps
`default_nettype none
`include "boot_power_defines.vh"
module boot_power_seq (
    input  wire        mclk_i,
    input  wire        rst_b_i,
    input  wire        main_low_voltage_input_i,
    input  wire        vbus_present_i,
    input  wire        regulated_from_vbus_i,
    input  wire [2:0]  db_mode_strap_i,
    input  wire [2:0]  cfg_strap_i,
    input  wire        cfg_load_done_i,
    input  wire        cfg_load_fail_i,
    input  wire        cfg_ports_enabled_i,
    input  wire [1:0]  cfg_role_i,
    input  wire        cfg_ext_switch_i,
    input  wire        cfg_pd_enabled_i,
    input  wire        cfg_alt_modes_i,
    input  wire        port_connected_i,
    input  wire        i2c_addr_match_i,
    input  wire        pd_msg_rx_i,
    input  wire        idle_req_i,
    input  wire        sleep_req_i,
    output reg         cfg_load_req_o,
    output reg         boot_done_o,
    output reg         cfg_from_load_o,
    output reg         ports_enabled_o,
    output reg  [1:0]  port_role_o,
    output reg         pd_enabled_o,
    output reg         alt_modes_o,
    output reg  [6:0]  src_watts_o,
    output reg  [3:0]  src_vmap_o,
    output reg  [8:0]  snk_min_cur_o,
    output reg  [8:0]  snk_max_cur_o,
    output reg         external_sink_gate_pin_o,
    output reg         first_high_voltage_path_o,
    output reg  [1:0]  pwr_state_o,
    output reg         osc_fast_en_o,
    output wire        osc_slow_en_o,
    output wire        core_tick_o,
    output wire        typec_detect_en_o,
    output reg         pd_comm_en_o,
    output reg         spi_en_o,
    output reg         i2c_en_o,
    output reg         pd_msg_fwd_o
);
    localparam [2:0] BOOT_STRAP   = 3'h0;
    localparam [2:0] BOOT_HOLD    = 3'h1;
    localparam [2:0] BOOT_LOAD    = 3'h2;
    localparam [2:0] BOOT_WAIT    = 3'h3;
    localparam [2:0] BOOT_RUN     = 3'h4;

    reg  [2:0]  boot_r;
    reg  [2:0]  boot_nxt;
    reg  [2:0]  db_r;
    reg  [2:0]  cfg_r;
    reg         loaded_r;
    reg  [1:0]  pwr_nxt;
    reg         det_prev_r;

    wire        rom_en;
    wire [1:0]  rom_role;
    wire        rom_ext;
    wire        rom_pd;
    wire        rom_alt;
    wire [6:0]  rom_watts;
    wire [3:0]  rom_vmap;
    wire [8:0]  rom_min;
    wire [8:0]  rom_max;

    function is_ext_db;
        input [2:0] m;
        begin
            is_ext_db = (m == `DB_HOLD_FOR_SUPPLY_EXT) ||
                        (m == `DB_CONTROLLER_WAIT_EXT);
        end
    endfunction

    function is_int_db;
        input [2:0] m;
        begin
            is_int_db = (m == `DB_HOLD_FOR_SUPPLY_INT) ||
                        (m == `DB_CONTROLLER_WAIT_INT);
        end
    endfunction

    default_profile_rom u_rom (
        .cfg_sel_i       (cfg_r),
        .ports_enabled_o (rom_en),
        .role_o          (rom_role),
        .ext_switch_o    (rom_ext),
        .pd_enabled_o    (rom_pd),
        .alt_modes_o     (rom_alt),
        .src_watts_o     (rom_watts),
        .src_vmap_o      (rom_vmap),
        .snk_min_cur_o   (rom_min),
        .snk_max_cur_o   (rom_max)
    );

    core_tick_divider u_div (
        .mclk_i      (mclk_i),
        .rst_b_i     (rst_b_i),
        .pwr_state_i (pwr_state_o),
        .core_tick_o (core_tick_o)
    );

    always @* begin
        boot_nxt = boot_r;
        case (boot_r)
            // straps land in db_r on this edge, so read the pins
            BOOT_STRAP: begin
                if (!main_low_voltage_input_i &&
                    (is_ext_db(db_mode_strap_i) ||
                     is_int_db(db_mode_strap_i) ||
                     db_mode_strap_i == `DB_NO_RESPONSE) &&
                    !(db_mode_strap_i == `DB_CONTROLLER_WAIT_INT ||
                      db_mode_strap_i == `DB_CONTROLLER_WAIT_EXT))
                    boot_nxt = BOOT_HOLD;
                else
                    boot_nxt = BOOT_LOAD;
            end
            BOOT_HOLD: begin
                if (main_low_voltage_input_i)
                    boot_nxt = BOOT_LOAD;
            end
            BOOT_LOAD: begin
                if (cfg_load_done_i)
                    boot_nxt = BOOT_RUN;
                else if (cfg_load_fail_i)
                    boot_nxt = BOOT_WAIT;
            end
            BOOT_WAIT: begin
                if (cfg_r != `CFG_INFINITE_WAIT)
                    boot_nxt = BOOT_RUN;
                else
                    boot_nxt = BOOT_LOAD;
            end
            default: boot_nxt = BOOT_RUN;
        endcase
    end

    // straps caught in the clocked domain after reset release
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            boot_r          <= BOOT_STRAP;
            db_r            <= `DB_NO_RESPONSE;
            cfg_r           <= `CFG_SAFE;
            loaded_r        <= 1'b0;
            cfg_load_req_o  <= 1'b0;
            boot_done_o     <= 1'b0;
        end else begin
            boot_r <= boot_nxt;
            if (boot_r == BOOT_STRAP) begin
                db_r  <= db_mode_strap_i;
                cfg_r <= cfg_strap_i;
            end
            if (boot_r == BOOT_LOAD && cfg_load_done_i)
                loaded_r <= 1'b1;
            cfg_load_req_o <= (boot_nxt == BOOT_LOAD);
            boot_done_o    <= (boot_nxt == BOOT_RUN);
        end
    end

    // port settings, loaded bundle wins over strapped profile
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_from_load_o           <= 1'b0;
            ports_enabled_o           <= 1'b0;
            port_role_o               <= `ROLE_DISABLED;
            pd_enabled_o              <= 1'b0;
            alt_modes_o               <= 1'b0;
            src_watts_o               <= 7'h00;
            src_vmap_o                <= 4'h0;
            snk_min_cur_o             <= 9'h000;
            snk_max_cur_o             <= 9'h000;
            external_sink_gate_pin_o  <= 1'b0;
            first_high_voltage_path_o <= 1'b0;
        end else begin
            cfg_from_load_o <= loaded_r;
            src_watts_o     <= rom_watts;
            src_vmap_o      <= rom_vmap;
            snk_min_cur_o   <= rom_min;
            snk_max_cur_o   <= rom_max;
            if (boot_r != BOOT_RUN) begin
                ports_enabled_o <= 1'b0;
                port_role_o     <= `ROLE_DISABLED;
                pd_enabled_o    <= 1'b0;
                alt_modes_o     <= 1'b0;
            end else if (loaded_r) begin
                ports_enabled_o <= cfg_ports_enabled_i;
                pd_enabled_o    <= cfg_pd_enabled_i;
                alt_modes_o     <= cfg_alt_modes_i;
                if (regulated_from_vbus_i && cfg_role_i != `ROLE_DISABLED)
                    port_role_o <= `ROLE_SINK;
                else
                    port_role_o <= cfg_role_i;
            end else if (cfg_r == `CFG_SAFE || !rom_en) begin
                ports_enabled_o <= 1'b0;
                pd_enabled_o    <= 1'b0;
                alt_modes_o     <= 1'b0;
                port_role_o     <= vbus_present_i && regulated_from_vbus_i ?
                                   `ROLE_SINK : `ROLE_DISABLED;
            end else begin
                ports_enabled_o <= rom_en;
                pd_enabled_o    <= rom_pd;
                alt_modes_o     <= rom_alt;
                if (regulated_from_vbus_i)
                    port_role_o <= `ROLE_SINK;
                else
                    port_role_o <= rom_role;
            end
            // dead-battery path stays closed until a run config takes over
            if (boot_r != BOOT_RUN) begin
                external_sink_gate_pin_o  <= vbus_present_i && is_ext_db(db_r);
                first_high_voltage_path_o <= vbus_present_i && is_int_db(db_r);
            end else begin
                external_sink_gate_pin_o  <= loaded_r ?
                    (cfg_ext_switch_i && cfg_role_i[1]) :
                    (rom_en ? (rom_ext && rom_role[1]) :
                     (vbus_present_i && is_ext_db(db_r)));
                first_high_voltage_path_o <= loaded_r ?
                    (!cfg_ext_switch_i && cfg_role_i[1]) :
                    (rom_en ? (!rom_ext && rom_role[1]) :
                     (vbus_present_i && !is_ext_db(db_r)));
            end
        end
    end

    // power state; wakes outrank requests to drop
    always @* begin
        pwr_nxt = pwr_state_o;
        case (pwr_state_o)
            `PWR_ACTIVE: begin
                if (sleep_req_i && !port_connected_i)
                    pwr_nxt = `PWR_SLEEP;
                else if (idle_req_i)
                    pwr_nxt = `PWR_IDLE;
            end
            `PWR_IDLE: begin
                if (port_connected_i != det_prev_r || i2c_addr_match_i ||
                    pd_msg_rx_i)
                    pwr_nxt = `PWR_ACTIVE;
                else if (sleep_req_i && !port_connected_i)
                    pwr_nxt = `PWR_SLEEP;
            end
            default: begin
                if (port_connected_i != det_prev_r || i2c_addr_match_i ||
                    port_connected_i)
                    pwr_nxt = `PWR_ACTIVE;
            end
        endcase
    end

    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            det_prev_r    <= 1'b0;
            pwr_state_o   <= `PWR_ACTIVE;
            osc_fast_en_o <= 1'b1;
            pd_comm_en_o  <= 1'b1;
            spi_en_o      <= 1'b1;
            i2c_en_o      <= 1'b1;
            pd_msg_fwd_o  <= 1'b0;
        end else begin
            det_prev_r    <= port_connected_i;
            pwr_state_o   <= pwr_nxt;
            osc_fast_en_o <= (pwr_nxt != `PWR_SLEEP);
            pd_comm_en_o  <= (pwr_nxt == `PWR_ACTIVE);
            spi_en_o      <= (pwr_nxt == `PWR_ACTIVE);
            i2c_en_o      <= (pwr_nxt != `PWR_SLEEP);
            pd_msg_fwd_o  <= pd_msg_rx_i && (pwr_state_o == `PWR_ACTIVE);
        end
    end

    assign osc_slow_en_o     = 1'b1;
    assign typec_detect_en_o = 1'b1;
endmodule // boot_power_seq
`default_nettype wire

// *** logic/boot_power_defines.vh ***
`ifndef BOOT_POWER_DEFINES_VH
`define BOOT_POWER_DEFINES_VH

// dead-battery strap codes
`define DB_NO_RESPONSE            3'h0
`define DB_HOLD_FOR_SUPPLY_INT    3'h1
`define DB_CONTROLLER_WAIT_INT    3'h2
`define DB_HOLD_FOR_SUPPLY_EXT    3'h3
`define DB_CONTROLLER_WAIT_EXT    3'h4
`define DB_NO_WAIT                3'h5

// default configuration strap codes
`define CFG_SAFE                  3'h0
`define CFG_INFINITE_WAIT         3'h1
`define CFG_PROFILE_1             3'h2
`define CFG_PROFILE_2             3'h3
`define CFG_PROFILE_3             3'h4
`define CFG_PROFILE_4             3'h5
`define CFG_PROFILE_5             3'h6

// port role codes
`define ROLE_DISABLED             2'h0
`define ROLE_SOURCE               2'h1
`define ROLE_SINK                 2'h2
`define ROLE_DUAL                 2'h3

// power state codes
`define PWR_ACTIVE                2'h0
`define PWR_IDLE                  2'h1
`define PWR_SLEEP                 2'h2

// source power in watts, voltage bitmap bit0=5v bit1=9v bit2=15v bit3=20v
`define SRC_W_15                  7'h0f
`define SRC_W_45                  7'h2d
`define SRC_W_60                  7'h3c
`define VMAP_5V                   4'h1
`define VMAP_5_TO_20V             4'hf
// current in 10 mA units
`define CUR_0A9                   9'h05a
`define CUR_3A0                   9'h12c

// mclk 250 MHz, period 4 ns
`define MCLK_PERIOD_NS            4
`define CORE_ACTIVE_KHZ           12000
`define CORE_IDLE_KHZ             5000
`define CORE_SLEEP_KHZ            100
`define MCLK_KHZ                  250000
`define DIV_ACTIVE  (`MCLK_KHZ / `CORE_ACTIVE_KHZ)
`define DIV_IDLE    (`MCLK_KHZ / `CORE_IDLE_KHZ)
`define DIV_SLEEP   (`MCLK_KHZ / `CORE_SLEEP_KHZ)
// divider terminal counts, one below each ratio
`define TICK_LIM_ACTIVE           12'h013
`define TICK_LIM_IDLE             12'h031
`define TICK_LIM_SLEEP            12'h9c3

`endif

// *** logic/core_tick_divider.v ***
`timescale 1ns/1ps
`default_nettype none
`include "boot_power_defines.vh"
module core_tick_divider (
    input  wire        mclk_i,
    input  wire        rst_b_i,
    input  wire [1:0]  pwr_state_i,
    output reg         core_tick_o
);
    reg  [11:0] cnt_r;
    reg  [11:0] limit;

    // limit drops to the new rate at once; a short last period is harmless
    always @* begin
        case (pwr_state_i)
            `PWR_ACTIVE: limit = `TICK_LIM_ACTIVE;
            `PWR_IDLE:   limit = `TICK_LIM_IDLE;
            default:     limit = `TICK_LIM_SLEEP;
        endcase
    end

    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r       <= 12'h000;
            core_tick_o <= 1'b0;
        end else if (cnt_r >= limit) begin
            cnt_r       <= 12'h000;
            core_tick_o <= 1'b1;
        end else begin
            cnt_r       <= cnt_r + 12'h001;
            core_tick_o <= 1'b0;
        end
    end
endmodule // core_tick_divider
`default_nettype wire

// *** logic/default_profile_rom.v ***
`timescale 1ns/1ps
`default_nettype none
`include "boot_power_defines.vh"
module default_profile_rom (
    input  wire [2:0]  cfg_sel_i,
    output reg         ports_enabled_o,
    output reg  [1:0]  role_o,
    output reg         ext_switch_o,
    output reg         pd_enabled_o,
    output reg         alt_modes_o,
    output reg  [6:0]  src_watts_o,
    output reg  [3:0]  src_vmap_o,
    output reg  [8:0]  snk_min_cur_o,
    output reg  [8:0]  snk_max_cur_o
);
    always @* begin
        ports_enabled_o = 1'b1;
        role_o          = `ROLE_DISABLED;
        ext_switch_o    = 1'b0;
        pd_enabled_o    = 1'b1;
        alt_modes_o     = 1'b0;
        src_watts_o     = 7'h00;
        src_vmap_o      = 4'h0;
        snk_min_cur_o   = 9'h000;
        snk_max_cur_o   = 9'h000;
        case (cfg_sel_i)
            `CFG_PROFILE_1: begin
                role_o       = `ROLE_SOURCE;
                pd_enabled_o = 1'b0;
                src_watts_o  = `SRC_W_15;
                src_vmap_o   = `VMAP_5V;
            end
            `CFG_PROFILE_2: begin
                role_o      = `ROLE_SOURCE;
                src_watts_o = `SRC_W_45;
                src_vmap_o  = `VMAP_5_TO_20V;
            end
            `CFG_PROFILE_3: begin
                role_o        = `ROLE_SINK;
                snk_min_cur_o = `CUR_0A9;
                snk_max_cur_o = `CUR_3A0;
            end
            `CFG_PROFILE_4: begin
                role_o      = `ROLE_SOURCE;
                src_watts_o = `SRC_W_60;
                src_vmap_o  = `VMAP_5_TO_20V;
            end
            `CFG_PROFILE_5: begin
                role_o        = `ROLE_DUAL;
                ext_switch_o  = 1'b1;
                src_watts_o   = `SRC_W_15;
                src_vmap_o    = `VMAP_5V;
                snk_min_cur_o = `CUR_0A9;
                snk_max_cur_o = `CUR_3A0;
            end
            default: begin
                ports_enabled_o = 1'b0;
                pd_enabled_o    = 1'b0;
            end
        endcase
    end
endmodule // default_profile_rom
`default_nettype wire

// *** tb/cfg_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cfg_source_model (
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    input  wire logic       cfg_load_req_i,
    input  wire logic       respond_i,
    input  wire logic [3:0] n_fail_i,
    output var  logic       cfg_load_done_o,
    output var  logic       cfg_load_fail_o
);
    logic [1:0] cnt;
    logic [3:0] fails;
    // answers a few cycles after the request opens; fails come first
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 2'h0;
            fails <= 4'h0;
            cfg_load_done_o <= 1'b0;
            cfg_load_fail_o <= 1'b0;
        end else begin
            cfg_load_done_o <= 1'b0;
            cfg_load_fail_o <= 1'b0;
            cnt <= cnt + 2'h1;
            if (!cfg_load_req_i || cfg_load_done_o || cfg_load_fail_o) begin
                cnt <= 2'h0;
            end else if (cnt == 2'h3) begin
                if (fails < n_fail_i) begin
                    fails <= fails + 4'h1;
                    cfg_load_fail_o <= 1'b1;
                end else begin
                    cfg_load_done_o <= respond_i;
                end
            end
        end
    end
endmodule // cfg_source_model
`default_nettype wire

// *** tb/boot_power_seq_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "boot_power_defines.vh"
module boot_power_seq_assertions (
    input wire logic       mclk_i, rst_b_i, port_connected_i,
    input wire logic       i2c_addr_match_i, pd_msg_rx_i, sleep_req_i,
    input wire logic       regulated_from_vbus_i, cfg_load_done_i,
    input wire logic       cfg_load_req_o, boot_done_o, osc_fast_en_o,
    input wire logic       osc_slow_en_o, typec_detect_en_o, pd_comm_en_o,
    input wire logic       spi_en_o, i2c_en_o, pd_msg_fwd_o,
    input wire logic [1:0] port_role_o, pwr_state_o
);
    wire active   = pwr_state_o == `PWR_ACTIVE;
    wire idle     = pwr_state_o == `PWR_IDLE;
    wire sleeping = pwr_state_o == `PWR_SLEEP;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    state_legal_a:
        assert property (active || idle || sleeping)
        else $error("power state code out of range");
    sleep_connected_a:
        assert property (!sleeping && port_connected_i |=> !sleeping)
        else $error("sleep entered while connected");
    osc_state_a:
        assert property (osc_fast_en_o == !sleeping && osc_slow_en_o)
        else $error("oscillator enables wrong for state");
    active_only_a:
        assert property (pd_comm_en_o == active && spi_en_o == active
                         && typec_detect_en_o)
        else $error("pd, spi or detection enable wrong");
    i2c_avail_a:
        assert property (i2c_en_o == !sleeping)
        else $error("i2c enable wrong for state");
    wake_i2c_a:
        assert property (!active && i2c_addr_match_i |=> active)
        else $error("no wake on addressed i2c");
    wake_attach_a:
        assert property (!active && $changed(port_connected_i) |=> active)
        else $error("no wake on attach or detach");
    pd_wake_a:
        assert property (idle && pd_msg_rx_i |=> active && !pd_msg_fwd_o)
        else $error("pd wake from idle wrong");
    pd_asleep_a:
        assert property (sleeping && pd_msg_rx_i && sleep_req_i
            && !i2c_addr_match_i && $stable(port_connected_i) |=> sleeping)
        else $error("pd message woke from sleep");
    load_done_a:
        assert property (cfg_load_req_o && cfg_load_done_i |=> boot_done_o)
        else $error("boot not done after load");
    vbus_sink_a:
        assert property (regulated_from_vbus_i [*3] |->
            port_role_o != `ROLE_SOURCE && port_role_o != `ROLE_DUAL)
        else $error("sourcing while fed from bus");
    sleep_c: cover property (sleeping);
    idle_wake_c: cover property (idle && pd_msg_rx_i);
    boot_c: cover property ($rose(boot_done_o));
endmodule // boot_power_seq_assertions
bind boot_power_seq boot_power_seq_assertions chk (
    .mclk_i, .rst_b_i, .port_connected_i, .i2c_addr_match_i, .pd_msg_rx_i,
    .sleep_req_i, .regulated_from_vbus_i, .cfg_load_done_i, .cfg_load_req_o,
    .boot_done_o, .osc_fast_en_o, .osc_slow_en_o, .typec_detect_en_o,
    .pd_comm_en_o, .spi_en_o, .i2c_en_o, .pd_msg_fwd_o, .port_role_o,
    .pwr_state_o
);
`default_nettype wire

// *** tb/boot_power_seq_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "boot_power_defines.vh"
module boot_power_seq_tb;
    logic       mclk_i, rst_b_i, main_low_voltage_input_i, vbus_present_i;
    logic       regulated_from_vbus_i, cfg_load_done_i, cfg_load_fail_i;
    logic       cfg_ports_enabled_i, cfg_ext_switch_i, cfg_pd_enabled_i;
    logic       cfg_alt_modes_i, port_connected_i, i2c_addr_match_i;
    logic       pd_msg_rx_i, idle_req_i, sleep_req_i, respond;
    logic       cfg_load_req_o, boot_done_o, cfg_from_load_o;
    logic       ports_enabled_o, pd_enabled_o, alt_modes_o, core_tick_o;
    logic       external_sink_gate_pin_o, first_high_voltage_path_o;
    logic       osc_fast_en_o, osc_slow_en_o, typec_detect_en_o;
    logic       pd_comm_en_o, spi_en_o, i2c_en_o, pd_msg_fwd_o;
    logic [1:0] cfg_role_i, port_role_o, pwr_state_o;
    logic [2:0] db_mode_strap_i, cfg_strap_i;
    logic [3:0] n_fail, src_vmap_o;
    logic [6:0] src_watts_o;
    logic [8:0] snk_min_cur_o, snk_max_cur_o;
    int         n_errors = 0, cmp_count = 0, cyc = 0, gap, k;
    logic [1:0] roles [5] = '{`ROLE_SOURCE, `ROLE_SOURCE, `ROLE_SINK,
                              `ROLE_SOURCE, `ROLE_DUAL};
    logic [10:0] srcs [5] = '{{`SRC_W_15, `VMAP_5V},
        {`SRC_W_45, `VMAP_5_TO_20V}, 11'h0, {`SRC_W_60, `VMAP_5_TO_20V},
        {`SRC_W_15, `VMAP_5V}};

    boot_power_seq dut (
        .mclk_i, .rst_b_i, .main_low_voltage_input_i, .vbus_present_i,
        .regulated_from_vbus_i, .db_mode_strap_i, .cfg_strap_i,
        .cfg_load_done_i, .cfg_load_fail_i, .cfg_ports_enabled_i,
        .cfg_role_i, .cfg_ext_switch_i, .cfg_pd_enabled_i, .cfg_alt_modes_i,
        .port_connected_i, .i2c_addr_match_i, .pd_msg_rx_i, .idle_req_i,
        .sleep_req_i, .cfg_load_req_o, .boot_done_o, .cfg_from_load_o,
        .ports_enabled_o, .port_role_o, .pd_enabled_o, .alt_modes_o,
        .src_watts_o, .src_vmap_o, .snk_min_cur_o, .snk_max_cur_o,
        .external_sink_gate_pin_o, .first_high_voltage_path_o,
        .pwr_state_o, .osc_fast_en_o, .osc_slow_en_o, .core_tick_o,
        .typec_detect_en_o, .pd_comm_en_o, .spi_en_o, .i2c_en_o,
        .pd_msg_fwd_o
    );
    cfg_source_model partner (
        .mclk_i, .rst_b_i, .cfg_load_req_i(cfg_load_req_o),
        .respond_i(respond), .n_fail_i(n_fail),
        .cfg_load_done_o(cfg_load_done_i), .cfg_load_fail_o(cfg_load_fail_i)
    );

    task automatic tk(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic hit(input logic pd);
        pd_msg_rx_i = pd;
        i2c_addr_match_i = !pd;
        tk(1);
        pd_msg_rx_i = 1'b0;
        i2c_addr_match_i = 1'b0;
    endtask
    // straps and supplies are set while reset is held; the main supply may rise later
    task automatic boot(input logic [2:0] db, cf, input logic v3, rv);
        rst_b_i = 1'b0;
        db_mode_strap_i = db;
        cfg_strap_i = cf;
        main_low_voltage_input_i = v3;
        vbus_present_i = 1'b1;
        regulated_from_vbus_i = rv;
        idle_req_i = 1'b0;
        sleep_req_i = 1'b0;
        port_connected_i = 1'b0;
        tk(6);
        rst_b_i = 1'b1;
    endtask
    task automatic wait_boot();
        int i;
        for (i = 0; i < 300 && boot_done_o !== 1'b1; i++) tk(1);
        chk(boot_done_o, 1'b1);
        tk(3);
    endtask
    // the first tick may belong to the old rate, so measure the next gap
    task automatic tick_gap();
        int i;
        for (i = 0; i < 3000 && core_tick_o !== 1'b1; i++) tk(1);
        tk(1);
        for (gap = 1; gap < 3000 && core_tick_o !== 1'b1; gap++) tk(1);
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    // whole run needs about 5500 cycles
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            stop_test();
        end
    end

    initial begin
        respond = 1'b1;
        n_fail = 4'h0;
        cfg_ports_enabled_i = 1'b1;
        cfg_role_i = `ROLE_SINK;
        cfg_ext_switch_i = 1'b0;
        cfg_pd_enabled_i = 1'b1;
        cfg_alt_modes_i = 1'b1;
        pd_msg_rx_i = 1'b0;
        i2c_addr_match_i = 1'b0;
        boot(`DB_NO_WAIT, `CFG_PROFILE_1, 1'b1, 1'b0);
        tk(2);
        chk({cfg_load_req_o, boot_done_o}, 2'h2);
        wait_boot();
        chk({cfg_from_load_o, port_role_o, alt_modes_o}, 4'hd);
        tick_gap();
        chk(gap, 20);
        idle_req_i = 1'b1;
        tk(2);
        chk(pwr_state_o, `PWR_IDLE);
        tick_gap();
        chk(gap, 50);
        hit(1'b1);
        chk({pwr_state_o, pd_msg_fwd_o}, {`PWR_ACTIVE, 1'b0});
        tk(3);
        hit(1'b0);
        chk(pwr_state_o, `PWR_ACTIVE);
        idle_req_i = 1'b0;
        sleep_req_i = 1'b1;
        port_connected_i = 1'b1;
        tk(4);
        chk(pwr_state_o == `PWR_SLEEP, 1'b0);
        hit(1'b1);
        chk(pd_msg_fwd_o, 1'b1);
        port_connected_i = 1'b0;
        tk(4);
        chk({pwr_state_o, osc_fast_en_o, i2c_en_o},
            {`PWR_SLEEP, 2'h0});
        tick_gap();
        chk(gap, 2500);
        hit(1'b1);
        chk(pwr_state_o, `PWR_SLEEP);
        port_connected_i = 1'b1;
        tk(1);
        chk(pwr_state_o, `PWR_ACTIVE);
        port_connected_i = 1'b0;
        tk(4);
        hit(1'b0);
        chk(pwr_state_o, `PWR_ACTIVE);
        respond = 1'b0;
        n_fail = 4'h1;
        for (k = 0; k < 5; k++) begin
            boot(`DB_NO_WAIT, 3'(`CFG_PROFILE_1 + k), 1'b1, 1'b0);
            wait_boot();
            chk({cfg_from_load_o, ports_enabled_o, port_role_o},
                {2'h1, roles[k]});
            chk({pd_enabled_o, alt_modes_o},
                {k != 0, 1'b0});
            if (k == 2 || k == 4)
                chk({snk_min_cur_o, snk_max_cur_o},
                    {`CUR_0A9, `CUR_3A0});
            if (k != 2)
                chk({src_watts_o, src_vmap_o},
                    srcs[k]);
        end
        boot(`DB_NO_WAIT, `CFG_SAFE, 1'b0, 1'b1);
        wait_boot();
        chk({ports_enabled_o, first_high_voltage_path_o}, 2'h1);
        boot(`DB_NO_WAIT, `CFG_PROFILE_2, 1'b0, 1'b1);
        wait_boot();
        chk(port_role_o inside {`ROLE_SOURCE, `ROLE_DUAL}, 1'b0);
        boot(`DB_HOLD_FOR_SUPPLY_EXT, `CFG_SAFE, 1'b0, 1'b1);
        tk(4);
        chk({cfg_load_req_o, external_sink_gate_pin_o,
             first_high_voltage_path_o}, 3'h2);
        main_low_voltage_input_i = 1'b1;
        wait_boot();
        n_fail = 4'h5;
        boot(`DB_CONTROLLER_WAIT_INT, `CFG_INFINITE_WAIT, 1'b0, 1'b1);
        tk(40);
        chk({cfg_load_req_o, boot_done_o, external_sink_gate_pin_o,
             first_high_voltage_path_o}, 4'h9);
        respond = 1'b1;
        wait_boot();
        chk(cfg_from_load_o, 1'b1);
        stop_test();
    end
endmodule // boot_power_seq_tb
`default_nettype wire
